// ===== sector_map_defs.svh
// Purpose: Constants of the sector map detection table and of the controller registers
// Assumes: 32-bit table dwords, one aligned word per controller register
// Notes:   Definitions only
`ifndef SECTOR_MAP_DEFS_SVH
`define SECTOR_MAP_DEFS_SVH

// Table dword byte offsets within the parameter area
`define TBL_DET1_CMD_OFS     8'h48
`define TBL_DET1_ADDR_OFS    8'h4C
`define TBL_DET2_CMD_OFS     8'h50
`define TBL_DET2_ADDR_OFS    8'h54

// Detection command descriptor fields
`define DESC_MASK_MSB        31
`define DESC_MASK_LSB        24
`define DESC_ALEN_MSB        23
`define DESC_ALEN_LSB        22
`define DESC_RSV_HI_MSB      21
`define DESC_RSV_HI_LSB      20
`define DESC_LAT_MSB         19
`define DESC_LAT_LSB         16
`define DESC_INSTR_MSB       15
`define DESC_INSTR_LSB       8
`define DESC_RSV_LO_MSB      7
`define DESC_RSV_LO_LSB      2
`define DESC_KIND_BIT        1
`define DESC_END_BIT         0

`define DET_READ_MASK        8'h08
`define DET_ALEN_VARIABLE    2'h3
`define DET_RSV_HI           2'h3
`define DET_LAT_VARIABLE     4'hF
`define DET_INSTR_READ_ANY   8'h65
`define DET_RSV_LO           6'h3F
`define DET_KIND_COMMAND     1'h0
`define DET_NOT_END          1'h0

// Detection addresses of configuration register 3 of each die
`define DET_ADDR_LOW_DIE     32'h00000004
`define DET_ADDR_HIGH_DIE    32'h04000004
`define DIE_SELECT_ADDR_BIT  26

// Architecture bit position within configuration register 3
`define ARCH_BIT             3

// Controller registers (byte addresses)
`define REG_CTRL_OFS         8'h00
`define REG_STATUS_OFS       8'h04
`define REG_RAW_OFS          8'h08
`define REG_DESC_OFS         8'h0C
`define CTRL_START_BIT       0
`define STAT_BUSY_BIT        0
`define STAT_DONE_BIT        1
`define STAT_ERR_BIT         2
`define STAT_INDEX_LSB       4
`define STAT_MAP_LSB         8
`define HRESP_OKAY           1'h0
`define HTRANS_NONSEQ        2'h2
`define HSIZE_WORD           3'h2

`endif

// ===== sector_map_pkg.sv
// Purpose: Types shared by both ends of the sector map detection link
// Assumes: Constants live in sector_map_defs.svh
// Notes:   Map codes equal the index values they stand for
package sector_map_pkg;

  typedef enum logic [1:0] {
    MAP_UNSUPPORTED = 2'h0,
    MAP_PARAM_BOTTOM = 2'h1,
    MAP_PARAM_TOP    = 2'h2,
    MAP_UNIFORM      = 2'h3
  } sector_map_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_ISSUE = 3'h2,
    ST_WAIT  = 3'h4
  } detect_state_e;

  typedef logic [31:0] dword_t;

endpackage : sector_map_pkg

// ===== sector_map_if.sv
// Purpose: Link between detection controller and device parameter table
// Assumes: One clock shared by both ends
// Notes:   One request outstanding at a time
interface sector_map_if;
  logic         req;
  logic         req_table;
  logic [7:0]   req_instr;
  logic [31:0]  req_addr;
  logic         ack;
  logic [31:0]  rdata;

  modport device (
    input  req,
    input  req_table,
    input  req_instr,
    input  req_addr,
    output ack,
    output rdata
  );

  modport host (
    output req,
    output req_table,
    output req_instr,
    output req_addr,
    input  ack,
    input  rdata
  );
endinterface : sector_map_if

// ===== sector_map_device.sv
// Purpose: Device end: detection descriptors and die configuration register 3 reads
// Assumes: Die register contents arrive as levels on the user side
// Notes:   Every request is answered one cycle after it is seen
`include "sector_map_defs.svh"

module sector_map_device (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  // Link
  sector_map_if.device                    link,
  // Die configuration registers
  input  wire logic [7:0]                 low_nonvolatile_config_reg3,
  input  wire logic [7:0]                 high_nonvolatile_config_reg3,
  // Status
  output sector_map_pkg::sector_map_e     active_map,
  output logic                            config_invalid
);
  import sector_map_pkg::*;

  dword_t det_cmd;
  dword_t next_rdata;
  logic   low_arch;
  logic   high_arch;

  // Descriptor with reserved fields all ones
  assign det_cmd = {`DET_READ_MASK, `DET_ALEN_VARIABLE, `DET_RSV_HI,
                    `DET_LAT_VARIABLE, `DET_INSTR_READ_ANY,
                    `DET_RSV_LO, `DET_KIND_COMMAND, `DET_NOT_END};
  assign low_arch  = low_nonvolatile_config_reg3[`ARCH_BIT];
  assign high_arch = high_nonvolatile_config_reg3[`ARCH_BIT];

  always_comb begin
    next_rdata = 32'h00000000;
    if (link.req_table) begin
      case (link.req_addr[7:0])
        `TBL_DET1_CMD_OFS:  next_rdata = det_cmd;
        `TBL_DET1_ADDR_OFS: next_rdata = `DET_ADDR_LOW_DIE;
        `TBL_DET2_CMD_OFS:  next_rdata = det_cmd;
        `TBL_DET2_ADDR_OFS: next_rdata = `DET_ADDR_HIGH_DIE;
        default:            next_rdata = 32'h00000000;
      endcase
    end else if (link.req_instr == `DET_INSTR_READ_ANY) begin
      // The whole address, low die or high die detection address, picks the die holding the register
      if (link.req_addr == `DET_ADDR_LOW_DIE) begin
        next_rdata = {24'h000000, low_nonvolatile_config_reg3};
      end else if (link.req_addr == `DET_ADDR_HIGH_DIE) begin
        next_rdata = {24'h000000, high_nonvolatile_config_reg3};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link.ack   <= 1'b0;
      link.rdata <= 32'h00000000;
    end else begin
      link.ack   <= link.req;
      if (link.req) begin
        link.rdata <= next_rdata;
      end
    end
  end

  // Low die is the upper index bit; both hybrid has no map
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      active_map     <= MAP_UNSUPPORTED;
      config_invalid <= 1'b0;
    end else begin
      active_map     <= sector_map_e'({low_arch, high_arch});
      config_invalid <= ~low_arch & ~high_arch;
    end
  end

endmodule : sector_map_device

// ===== sector_map_host.sv
// Purpose: Host end: reads detection descriptors, fetches both architecture bits, forms map index
// Assumes: AHB-Lite single word transfers, one slave, response always OKAY
// Notes:   Every register answer takes one wait state so outputs stay registered
`include "sector_map_defs.svh"

module sector_map_host #(
  parameter int ADDR_WIDTH = 8
) (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  // AHB-Lite slave
  input  wire logic                      hsel,
  input  wire logic [ADDR_WIDTH-1:0]     haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  // Link
  sector_map_if.host                     link,
  // Result
  output sector_map_pkg::sector_map_e    current_map,
  output logic                           map_valid
);
  import sector_map_pkg::*;

  if (ADDR_WIDTH < 4) begin : g_width_check
    $error("ADDR_WIDTH too small for the register map");
  end

  detect_state_e state;
  logic [2:0]    step;
  dword_t        cmd_desc [2];
  dword_t        cmd_addr [2];
  logic [7:0]    raw_byte [2];
  logic [1:0]    index;
  logic          busy;
  logic          done;
  logic          err;
  logic          start;
  logic          desc_bad;
  logic          pend;
  logic          pend_write;
  logic [7:0]    pend_addr;
  logic [31:0]   next_hrdata;
  logic [1:0]    got_bit;
  logic [7:0]    bit_src [2];
  logic [1:0]    next_index;

  // Bus slave: address phase captured, one wait state, then answer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pend       <= 1'b0;
      pend_write <= 1'b0;
      pend_addr  <= 8'h00;
      hreadyout  <= 1'b1;
      hresp      <= `HRESP_OKAY;
    end else begin
      hresp <= `HRESP_OKAY;
      if (hsel && hready && htrans == `HTRANS_NONSEQ) begin
        pend       <= 1'b1;
        pend_write <= hwrite;
        pend_addr  <= 8'(haddr);
        hreadyout  <= 1'b0;
      end else if (pend) begin
        pend      <= 1'b0;
        hreadyout <= 1'b1;
      end
    end
  end

  assign start = pend && pend_write && pend_addr == `REG_CTRL_OFS && hwdata[`CTRL_START_BIT];

  always_comb begin
    case (pend_addr)
      `REG_STATUS_OFS: next_hrdata = {22'h000000, index, 2'h0, index, 1'b0, err, done, busy};
      `REG_RAW_OFS:    next_hrdata = {16'h0000, raw_byte[1], raw_byte[0]};
      `REG_DESC_OFS:   next_hrdata = cmd_desc[0];
      default:         next_hrdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (pend && !pend_write) begin
      hrdata <= next_hrdata;
    end
  end

  // Descriptor check: command kind, not end, read-any instruction, bit three mask
  assign desc_bad = link.rdata[`DESC_KIND_BIT] != `DET_KIND_COMMAND
                 || link.rdata[`DESC_END_BIT] != `DET_NOT_END
                 || link.rdata[`DESC_INSTR_MSB:`DESC_INSTR_LSB] != `DET_INSTR_READ_ANY
                 || link.rdata[`DESC_ALEN_MSB:`DESC_ALEN_LSB] != `DET_ALEN_VARIABLE
                 || link.rdata[`DESC_LAT_MSB:`DESC_LAT_LSB] != `DET_LAT_VARIABLE
                 || link.rdata[`DESC_MASK_MSB:`DESC_MASK_LSB] != `DET_READ_MASK;

  // Steps 0-3 read the descriptors, steps 4-5 run the two detection reads
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state          <= ST_IDLE;
      step           <= 3'h0;
      link.req       <= 1'b0;
      link.req_table <= 1'b0;
      link.req_instr <= 8'h00;
      link.req_addr  <= 32'h00000000;
    end else begin
      link.req <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            step  <= 3'h0;
            state <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          link.req <= 1'b1;
          if (step < 3'h4) begin
            link.req_table <= 1'b1;
            link.req_instr <= 8'h00;
            link.req_addr  <= {24'h000000, 8'(`TBL_DET1_CMD_OFS + {step, 2'b00})};
          end else begin
            link.req_table <= 1'b0;
            link.req_instr <= cmd_desc[step[0]][`DESC_INSTR_MSB:`DESC_INSTR_LSB];
            link.req_addr  <= cmd_addr[step[0]];
          end
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (link.ack) begin
            if (step == 3'h5 || (step[0] == 1'b0 && step < 3'h4 && desc_bad)) begin
              state <= ST_IDLE;
            end else begin
              step  <= step + 3'h1;
              state <= ST_ISSUE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Latch descriptors and raw bytes as they return
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_desc[0] <= 32'h00000000;
      cmd_desc[1] <= 32'h00000000;
      cmd_addr[0] <= 32'h00000000;
      cmd_addr[1] <= 32'h00000000;
      raw_byte[0] <= 8'h00;
      raw_byte[1] <= 8'h00;
    end else if (state == ST_WAIT && link.ack) begin
      case (step)
        3'h0:    cmd_desc[0] <= link.rdata;
        3'h1:    cmd_addr[0] <= link.rdata;
        3'h2:    cmd_desc[1] <= link.rdata;
        3'h3:    cmd_addr[1] <= link.rdata;
        3'h4:    raw_byte[0] <= link.rdata[7:0];
        3'h5:    raw_byte[1] <= link.rdata[7:0];
        default: cmd_desc[0] <= cmd_desc[0];
      endcase
    end
  end

  // Second byte comes straight off the link so the index lands with the last answer
  assign bit_src[0] = raw_byte[0];
  assign bit_src[1] = link.rdata[7:0];

  // Each bit is one when the masked byte is non-zero
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_bit
      assign got_bit[gi] = |(bit_src[gi] & cmd_desc[gi][`DESC_MASK_MSB:`DESC_MASK_LSB]);
    end
  endgenerate

  // Low die is the more significant index bit
  assign next_index = {got_bit[0], got_bit[1]};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy        <= 1'b0;
      done        <= 1'b0;
      err         <= 1'b0;
      index       <= 2'h0;
      current_map <= MAP_UNSUPPORTED;
      map_valid   <= 1'b0;
    end else if (state == ST_IDLE && start) begin
      busy      <= 1'b1;
      done      <= 1'b0;
      err       <= 1'b0;
      map_valid <= 1'b0;
    end else if (state == ST_WAIT && link.ack) begin
      if (step[0] == 1'b0 && step < 3'h4 && desc_bad) begin
        busy <= 1'b0;
        done <= 1'b1;
        err  <= 1'b1;
      end else if (step == 3'h5) begin
        busy        <= 1'b0;
        done        <= 1'b1;
        index       <= next_index;
        // Both hybrid has no map in the table
        err         <= next_index == 2'h0;
        map_valid   <= next_index != 2'h0;
        current_map <= sector_map_e'(next_index);
      end
    end
  end

  // Keeps the unused size field read so the bus contract stays complete
  logic unused_size;
  assign unused_size = ^hsize;

endmodule : sector_map_host

// ===== sector_map_checker.sv
// Purpose: Link checks between detection controller and parameter table
// Assumes: One clock, synchronous active-high reset
// Notes:   Sees only the interface signals
module sector_map_checker (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Link
  input wire logic        req,
  input wire logic        req_table,
  input wire logic [7:0]  req_instr,
  input wire logic [31:0] req_addr,
  input wire logic        ack,
  input wire logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Both descriptor dwords carry the same command fields
  localparam logic [31:0] DESC_WORD = {8'h08, 2'h3, 2'h3, 4'hF, 8'h65, 6'h3F, 1'b0, 1'b0};

  sequence table_read(logic [7:0] ofs);
    req && req_table && req_addr[7:0] == ofs;
  endsequence

  a_ack_one_late: assert property (req |=> ack) else $error("ack missing one cycle after req");
  a_ack_no_req: assert property (!req |=> !ack) else $error("ack without req");
  a_req_spacing: assert property (req |=> !req ##1 !req) else $error("req closer than three cycles");
  a_rdata_holds: assert property (!ack |-> $stable(rdata)) else $error("rdata changed without ack");
  a_instr_read_any: assert property (req && !req_table |-> req_instr == 8'h65)
    else $error("register read with wrong instruction");
  a_reg_addr_die: assert property (req && !req_table |-> req_addr inside {32'h00000004, 32'h04000004})
    else $error("register read at wrong address");
  a_desc1_word: assert property (table_read(8'h48) |=> rdata == DESC_WORD)
    else $error("first descriptor word wrong");
  a_desc2_word: assert property (table_read(8'h50) |=> rdata == DESC_WORD)
    else $error("second descriptor word wrong");
  a_low_die_addr: assert property (table_read(8'h4C) |=> rdata == 32'h00000004)
    else $error("low die address word wrong");
  a_high_die_addr: assert property (table_read(8'h54) |=> rdata == 32'h04000004 && rdata[26])
    else $error("high die address word wrong");

  c_table_read: cover property (table_read(8'h48) ##3 table_read(8'h4C));
  c_low_die: cover property (req && !req_table && req_addr == 32'h00000004);
  c_high_die: cover property (req && !req_table && req_addr == 32'h04000004 ##1 ack);
endmodule : sector_map_checker

// ===== sector_map_config_detect_tb.sv
// Purpose: Self-checking bench for both ends of the sector map detection link
// Assumes: AHB-Lite single word transfers, hready taken from the one slave
// Notes:   hready and read data are taken at the rising edge, before the design's updates of that edge land
module sector_map_config_detect_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sector_map_pkg::*;

  logic        clk_sys;
  logic        rst;
  logic        hsel;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  dword_t      hwdata;
  logic        hreadyout;
  logic        hresp;
  dword_t      hrdata;
  logic [7:0]  low_b;
  logic [7:0]  high_b;
  sector_map_e current_map;
  sector_map_e active_map;
  logic        map_valid;
  logic        config_invalid;
  int          errors;
  int          checked;

  sector_map_if link_if ();

  sector_map_device i_sector_map_device (.clk_sys(clk_sys), .rst(rst), .link(link_if.device),
    .low_nonvolatile_config_reg3(low_b), .high_nonvolatile_config_reg3(high_b),
    .active_map(active_map), .config_invalid(config_invalid));

  sector_map_host i_sector_map_host (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link_if.host),
    .current_map(current_map), .map_valid(map_valid));

  sector_map_checker i_sector_map_checker (.clk_sys(clk_sys), .rst(rst), .req(link_if.req),
    .req_table(link_if.req_table), .req_instr(link_if.req_instr), .req_addr(link_if.req_addr),
    .ack(link_if.ack), .rdata(link_if.rdata));

  always #12.5 clk_sys = ~clk_sys;

  task automatic close_out();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task automatic cmp_word(input string what, input dword_t seen, input dword_t exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp_word

  task automatic cmp_map(input string what, input sector_map_e seen, input sector_map_e exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp_map

  task automatic cmp_bit(input string what, input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %b seen %b", what, exp, seen);
    end
  endtask : cmp_bit

  task automatic wait_ready(output dword_t data);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    // A wait that runs out shows here as a mismatch
    cmp_bit("hreadyout", hreadyout, 1'b1);
    cmp_bit("hresp", hresp, 1'b0);
    data = hrdata;
  endtask : wait_ready

  task automatic xfer(input logic w, input logic [7:0] a, input dword_t wd, output dword_t rd);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready(rd);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(rd);
  endtask : xfer

  // Used at start and again in mid-run, after a finished detection
  task automatic test_reset(input int cycles);
    dword_t rd;
    rst <= 1'b1;
    repeat (cycles) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    cmp_map("current_map", current_map, MAP_UNSUPPORTED);
    cmp_bit("map_valid", map_valid, 1'b0);
    xfer(1'b0, 8'h04, 32'h0, rd);
    cmp_word("status", rd & 32'h337, 32'h0);
    xfer(1'b0, 8'h10, 32'h0, rd);
    cmp_word("unmapped", rd, 32'h0);
    $display("test reset done");
  endtask : test_reset

  // Bytes other than 8'h00 and 8'h08 carry stray bits besides bit 3 so that only the mask decides
  task automatic test_map(input logic [7:0] lo, input logic [7:0] hi, input sector_map_e exp_map);
    dword_t     rd;
    logic [1:0] idx;
    int         n;
    idx = {(lo & 8'h08) != 8'h00, (hi & 8'h08) != 8'h00};
    low_b <= lo;
    high_b <= hi;
    xfer(1'b1, 8'h00, 32'h1, rd);
    n = 0;
    do begin
      xfer(1'b0, 8'h04, 32'h0, rd);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    cmp_word("status", rd & 32'h337, {22'h0, idx, 2'h0, idx, 1'b0, idx == 2'h0, 2'h2});
    cmp_map("current_map", current_map, exp_map);
    cmp_bit("map_valid", map_valid, idx != 2'h0);
    cmp_map("active_map", active_map, exp_map);
    cmp_bit("config_invalid", config_invalid, idx == 2'h0);
    xfer(1'b0, 8'h08, 32'h0, rd);
    cmp_word("raw", rd & 32'hFFFF, {16'h0, hi, lo});
    xfer(1'b0, 8'h0C, 32'h0, rd);
    cmp_word("desc", rd, {8'h08, 2'h3, 2'h3, 4'hF, 8'h65, 6'h3F, 1'b0, 1'b0});
    $display("test map %h done", idx);
  endtask : test_map

  initial begin
    clk_sys = 1'b0;
    hsel = 1'b1;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    low_b = 8'h00;
    high_b = 8'h00;
    errors = 0;
    checked = 0;
    test_reset(5);
    test_map(8'hF7, 8'h08, MAP_PARAM_BOTTOM);
    test_map(8'h08, 8'hF7, MAP_PARAM_TOP);
    test_map(8'hFF, 8'h0F, MAP_UNIFORM);
    test_map(8'h00, 8'hF7, MAP_UNSUPPORTED);
    test_map(8'h08, 8'h08, MAP_UNIFORM);
    test_reset(2);
    test_map(8'hF7, 8'h08, MAP_PARAM_BOTTOM);
    close_out();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #(25 * 20000);
    errors++;
    close_out();
  end
endmodule : sector_map_config_detect_tb
